/* File: twm_defs.vh */
// Constants shared by the two-wire bus master files
`ifndef TWM_DEFS_VH
`define TWM_DEFS_VH

// Serial byte framing
`define TWM_LAST_DATA_BIT 4'h7
`define TWM_ACK_SLOT 4'h8

// Bit positions in the interrupt enable vector
`define TWM_EN_DONE 0
`define TWM_EN_RXF 1
`define TWM_EN_TXE 2
`define TWM_EN_NO_ACKNOWLEDGE_FLAG 3

// Status flag reset values
`define TWM_DONE_RST 1'b1
`define TWM_TXE_RST 1'b1
`define TWM_RXF_RST 1'b0
`define TWM_NO_ACKNOWLEDGE_FLAG_RST 1'b0

// Fixed cycles added to every divided half period of the serial clock
`define TWM_DIV_BASE 16'h0004

// Byte kinds carried by the shifter
`define TWM_B_ADDR 2'h0
`define TWM_B_INTERNAL_ADDRESS_BYTES 2'h1
`define TWM_B_TX 2'h2
`define TWM_B_RX 2'h3

`endif

/* File: twm_clkgen.v */
// Half-period timer for the serial clock line
`timescale 1ns/1ps
`default_nettype none
`include "twm_defs.vh"

module twm_clkgen #(
	parameter WIDTH = 16
) (
	input wire ref_clk,
	input wire nrst,
	input wire run,
	input wire sel_low,
	input wire hold,
	input wire [2:0] clock_divider_exponent,
	input wire [7:0] clock_high_divider,
	input wire [7:0] clock_low_divider,
	output reg tick
);

	reg [WIDTH-1:0] count_q;
	wire [7:0] div_sel;
	wire [WIDTH-1:0] target;

	assign div_sel = sel_low ? clock_low_divider : clock_high_divider;
	// Half period = divider * 2^exponent + fixed base + 1 cycles, so a zero divider still leaves
	// room for the two-stage input synchronisers to settle before sampling
	assign target = ({{(WIDTH-8){1'b0}}, div_sel} << clock_divider_exponent) + `TWM_DIV_BASE;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			count_q <= {WIDTH{1'b0}};
			tick <= 1'b0;
		end else if (!run) begin
			count_q <= {WIDTH{1'b0}};
			tick <= 1'b0;
		end else if (hold) begin
			tick <= 1'b0;
		end else if (count_q >= target) begin
			count_q <= {WIDTH{1'b0}};
			tick <= 1'b1;
		end else begin
			count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
			tick <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* File: twm_master.v */
// Two-wire serial bus master: framing, addressing, byte engine and status flags
`timescale 1ns/1ps
`default_nettype none
`include "twm_defs.vh"

module twm_master (
	input wire ref_clk,
	input wire nrst,
	input wire serial_clock_line_i,
	output reg serial_clock_line_o,
	output reg serial_clock_line_oe_n,
	input wire serial_data_line_i,
	output reg serial_data_line_o,
	output reg serial_data_line_oe_n,
	input wire master_mode_enable,
	input wire slave_mode_disable,
	input wire read_direction_select,
	input wire [6:0] device_address_field,
	input wire [1:0] internal_address_size,
	input wire [23:0] internal_address_bytes,
	input wire [2:0] clock_divider_exponent,
	input wire [7:0] clock_high_divider,
	input wire [7:0] clock_low_divider,
	input wire start_cmd,
	input wire stop_cmd,
	input wire [7:0] transmit_holding_reg,
	input wire transmit_holding_write,
	output reg [7:0] receive_holding_reg,
	input wire receive_holding_read,
	input wire status_read,
	input wire [3:0] interrupt_enable_reg,
	output reg transmit_holding_empty,
	output reg receive_holding_full,
	output reg transfer_done_flag,
	output reg no_acknowledge_flag,
	output reg irq
);

	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_START = 5'h02;
	localparam [4:0] ST_BYTE = 5'h04;
	localparam [4:0] ST_STOP = 5'h08;
	localparam [4:0] ST_UNUSED = 5'h10;

	reg [4:0] state_q;
	reg [1:0] phase_q;
	reg [3:0] bit_cnt_q;
	reg [7:0] shift_q;
	reg [1:0] btype_q;
	reg [1:0] internal_address_bytes_left_q;
	reg rd_q;
	reg last_q;
	reg [7:0] hold_q;
	reg pend_q;
	reg stop_pend_q;
	reg scl_m_q;
	reg scl_s_q;
	reg sda_m_q;
	reg sda_s_q;

	wire tick;
	wire enabled;
	wire ack_ok;
	wire hold_clk;
	wire [7:0] internal_address_bytes_byte;
	wire [7:0] addr_w;
	wire [7:0] addr_r;
	wire [7:0] sh_in;
	wire [3:0] flag_vec;
	wire [3:0] irq_terms;

	// Two-flop synchronisers for the bus lines
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else begin
			scl_m_q <= serial_clock_line_i;
			scl_s_q <= scl_m_q;
			sda_m_q <= serial_data_line_i;
			sda_s_q <= sda_m_q;
		end
	end

	assign enabled = master_mode_enable & slave_mode_disable;
	assign ack_ok = ~sda_s_q;
	assign addr_w = {device_address_field, 1'b0};
	assign addr_r = {device_address_field, 1'b1};
	assign sh_in = {shift_q[6:0], sda_s_q};
	// A slave holding the clock low stretches the high half
	assign hold_clk = serial_clock_line_oe_n & ~scl_s_q;
	// Highest byte goes first; the count of bytes left picks the lane
	assign internal_address_bytes_byte = (internal_address_bytes_left_q == 2'h3) ? internal_address_bytes[23:16] :
		(internal_address_bytes_left_q == 2'h2) ? internal_address_bytes[15:8] :
		internal_address_bytes[7:0];

	assign flag_vec[`TWM_EN_DONE] = transfer_done_flag;
	assign flag_vec[`TWM_EN_RXF] = receive_holding_full;
	assign flag_vec[`TWM_EN_TXE] = transmit_holding_empty;
	assign flag_vec[`TWM_EN_NO_ACKNOWLEDGE_FLAG] = no_acknowledge_flag;

	// One mask gate per flag; a disabled flag never reaches the request line
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_irq_mask
			assign irq_terms[gi] = flag_vec[gi] & interrupt_enable_reg[gi];
		end
	endgenerate

	twm_clkgen #(
		.WIDTH(16)
	) u_clkgen (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.run(state_q != ST_IDLE),
		.sel_low(~serial_clock_line_oe_n),
		.hold(hold_clk),
		.clock_divider_exponent(clock_divider_exponent),
		.clock_high_divider(clock_high_divider),
		.clock_low_divider(clock_low_divider),
		.tick(tick)
	);

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			phase_q <= 2'h0;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			btype_q <= `TWM_B_ADDR;
			internal_address_bytes_left_q <= 2'h0;
			rd_q <= 1'b0;
			last_q <= 1'b0;
			hold_q <= 8'h00;
			pend_q <= 1'b0;
			stop_pend_q <= 1'b0;
			serial_clock_line_o <= 1'b0;
			serial_clock_line_oe_n <= 1'b1;
			serial_data_line_o <= 1'b0;
			serial_data_line_oe_n <= 1'b1;
			receive_holding_reg <= 8'h00;
			transmit_holding_empty <= `TWM_TXE_RST;
			receive_holding_full <= `TWM_RXF_RST;
			transfer_done_flag <= `TWM_DONE_RST;
			no_acknowledge_flag <= `TWM_NO_ACKNOWLEDGE_FLAG_RST;
			irq <= 1'b0;
		end else begin
			// Lines only ever pull low: the output value stays zero
			serial_clock_line_o <= 1'b0;
			serial_data_line_o <= 1'b0;
			// Clears come first so a same-cycle set below wins
			if (receive_holding_read) begin
				receive_holding_full <= 1'b0;
			end
			if (status_read) begin
				no_acknowledge_flag <= 1'b0;
			end
			case (state_q)
			ST_IDLE: begin
				serial_clock_line_oe_n <= 1'b1;
				serial_data_line_oe_n <= 1'b1;
				phase_q <= 2'h1;
				bit_cnt_q <= 4'h0;
				internal_address_bytes_left_q <= internal_address_size;
				rd_q <= read_direction_select;
				btype_q <= `TWM_B_ADDR;
				if (enabled && ((read_direction_select && start_cmd) ||
					(!read_direction_select && pend_q))) begin
					state_q <= ST_START;
					transfer_done_flag <= 1'b0;
					// Reads with an internal address open with a write phase
					if (read_direction_select && internal_address_size == 2'h0) begin
						shift_q <= addr_r;
					end else begin
						shift_q <= addr_w;
					end
				end
			end
			ST_START: begin
				if (tick) begin
					case (phase_q)
					2'h0: begin
						// Repeated start: release clock with data still released
						serial_clock_line_oe_n <= 1'b1;
						phase_q <= 2'h1;
					end
					2'h1: begin
						serial_data_line_oe_n <= 1'b0;
						phase_q <= 2'h2;
					end
					default: begin
						serial_clock_line_oe_n <= 1'b0;
						serial_data_line_oe_n <= shift_q[7];
						bit_cnt_q <= 4'h0;
						phase_q <= 2'h0;
						state_q <= ST_BYTE;
					end
					endcase
				end
			end
			ST_BYTE: begin
				if (tick && phase_q == 2'h0) begin
					serial_clock_line_oe_n <= 1'b1;
					phase_q <= 2'h1;
				end else if (tick) begin
					phase_q <= 2'h0;
					serial_clock_line_oe_n <= 1'b0;
					if (bit_cnt_q != `TWM_ACK_SLOT) begin
						shift_q <= sh_in;
						bit_cnt_q <= bit_cnt_q + 4'h1;
						if (bit_cnt_q == `TWM_LAST_DATA_BIT) begin
							if (btype_q == `TWM_B_RX) begin
								receive_holding_reg <= sh_in;
								receive_holding_full <= 1'b1;
								// Acknowledge unless stop was requested
								serial_data_line_oe_n <= stop_pend_q;
								last_q <= stop_pend_q;
							end else begin
								serial_data_line_oe_n <= 1'b1;
							end
						end else if (btype_q == `TWM_B_RX) begin
							serial_data_line_oe_n <= 1'b1;
						end else begin
							serial_data_line_oe_n <= shift_q[6];
						end
					end else begin
						bit_cnt_q <= 4'h0;
						if (btype_q == `TWM_B_RX) begin
							if (last_q) begin
								state_q <= ST_STOP;
								serial_data_line_oe_n <= 1'b0;
							end else begin
								serial_data_line_oe_n <= 1'b1;
							end
						end else if (!ack_ok) begin
							no_acknowledge_flag <= 1'b1;
							// Drop a refused byte, or idle would restart the write
							// on its own and keep hammering a silent slave
							pend_q <= 1'b0;
							transmit_holding_empty <= 1'b1;
							state_q <= ST_STOP;
							serial_data_line_oe_n <= 1'b0;
						end else if (btype_q != `TWM_B_TX && internal_address_bytes_left_q != 2'h0) begin
							shift_q <= internal_address_bytes_byte;
							serial_data_line_oe_n <= internal_address_bytes_byte[7];
							internal_address_bytes_left_q <= internal_address_bytes_left_q - 2'h1;
							btype_q <= `TWM_B_INTERNAL_ADDRESS_BYTES;
						end else if (rd_q && btype_q == `TWM_B_ADDR) begin
							btype_q <= `TWM_B_RX;
							serial_data_line_oe_n <= 1'b1;
						end else if (rd_q) begin
							// Internal address done: turn the bus round
							state_q <= ST_START;
							phase_q <= 2'h0;
							shift_q <= addr_r;
							btype_q <= `TWM_B_ADDR;
							serial_data_line_oe_n <= 1'b1;
						end else if (pend_q && !stop_pend_q) begin
							shift_q <= hold_q;
							serial_data_line_oe_n <= hold_q[7];
							pend_q <= 1'b0;
							transmit_holding_empty <= 1'b1;
							btype_q <= `TWM_B_TX;
						end else begin
							state_q <= ST_STOP;
							serial_data_line_oe_n <= 1'b0;
						end
					end
				end
			end
			ST_STOP: begin
				if (tick) begin
					case (phase_q)
					2'h0: begin
						serial_clock_line_oe_n <= 1'b1;
						phase_q <= 2'h1;
					end
					2'h1: begin
						serial_data_line_oe_n <= 1'b1;
						phase_q <= 2'h2;
					end
					default: begin
						// Bus free time ends here
						state_q <= ST_IDLE;
						stop_pend_q <= 1'b0;
						transfer_done_flag <= 1'b1;
					end
					endcase
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
			// Port-side sets last, so they beat a same-cycle consume
			if (transmit_holding_write) begin
				hold_q <= transmit_holding_reg;
				pend_q <= 1'b1;
				transmit_holding_empty <= 1'b0;
			end
			if (stop_cmd) begin
				stop_pend_q <= 1'b1;
			end
			// Registered so the request line is glitch free, one cycle behind the flags
			irq <= |irq_terms;
		end
	end

endmodule
`default_nettype wire

/* File: twm_master_properties.sv */
// Port checks for the two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module twm_checker (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic serial_clock_line_o,
	input wire logic serial_clock_line_oe_n,
	input wire logic serial_data_line_o,
	input wire logic serial_data_line_oe_n,
	input wire logic transmit_holding_write,
	input wire logic receive_holding_read,
	input wire logic [3:0] interrupt_enable_reg,
	input wire logic transmit_holding_empty,
	input wire logic receive_holding_full,
	input wire logic transfer_done_flag,
	input wire logic no_acknowledge_flag,
	input wire logic irq
);
	wire [3:0] en_flags = interrupt_enable_reg & {no_acknowledge_flag,
		transmit_holding_empty, receive_holding_full, transfer_done_flag};
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_open_drain: assert property (!serial_clock_line_o && !serial_data_line_o)
		else $error("line driven high");
	a_irq_masked: assert property ($past(nrst) |-> irq == |$past(en_flags))
		else $error("irq mismatch");
	a_start_busy: assert property ($fell(serial_data_line_oe_n) && serial_clock_line_oe_n
		&& $past(serial_clock_line_oe_n) |-> !transfer_done_flag)
		else $error("start while idle");
	a_stop_done: assert property ($rose(serial_data_line_oe_n) && serial_clock_line_oe_n
		&& $past(serial_clock_line_oe_n) |-> ##[0:60] transfer_done_flag)
		else $error("no done after stop");
	a_write_clears: assert property (transmit_holding_write |=> !transmit_holding_empty)
		else $error("tx empty stuck");
	a_read_clears: assert property (receive_holding_read |=> !receive_holding_full)
		else $error("rx full stuck");
	a_idle_released: assert property (transfer_done_flag [*2]
		|-> serial_clock_line_oe_n && serial_data_line_oe_n)
		else $error("line held while idle");
	a_txe_busy: assert property ($rose(transmit_holding_empty)
		|-> !transfer_done_flag)
		else $error("tx empty set while idle");
endmodule
bind twm_master twm_checker twm_checker_inst (.*);
`default_nettype wire

/* File: twm_slave_model.sv */
// Behavioural slave on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module twm_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic nak,
	input wire logic stretch,
	input wire logic [7:0] txb,
	output var logic scl_pull,
	output var logic sda_pull,
	output var logic [7:0] got,
	output var logic [7:0] adr,
	output var int nst,
	output var int nsp,
	output var int macks
);
	int cnt;
	logic first, rd, quiet;
	logic [7:0] sh;
	initial begin
		{scl_pull, sda_pull, first, rd, quiet, got, adr, sh} = 0;
		{nst, nsp, macks, cnt} = 0;
	end
	// Look a moment later: a data edge on the clock's falling edge is no frame mark
	always @(negedge sda) begin
		#1;
		if (scl) begin
			nst++;
			cnt = 0;
			{first, rd, quiet} = 3'h4;
		end
	end
	always @(posedge sda) begin
		#1;
		if (scl) nsp++;
	end
	always @(posedge scl) begin
		if (cnt < 8)
			sh = {sh[6:0], sda};
		else if (rd && !first)
			if (sda) quiet = 1; else macks++;
		cnt++;
		if (cnt == 8)
			if (first) adr = sh; else if (!rd) got = sh;
	end
	always @(negedge scl) begin
		if (cnt == 9) begin
			cnt = 0;
			if (first) begin
				rd = sh[0];
				quiet = nak;
			end
			first = 0;
		end
		if (cnt == 8)
			sda_pull = !(rd && !first) && !nak;
		else
			sda_pull = rd && !first && !quiet && !txb[7 - cnt];
		// Slow answer: hold the clock low to stretch the low phase
		if (stretch) begin
			scl_pull = 1;
			#300;
			scl_pull = 0;
		end
	end
endmodule
`default_nettype wire

/* File: twm_tb_top.sv */
// Random and corner-case bench for the two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module twm_master_tb_top;
	logic ref_clk, nrst, serial_clock_line_o, serial_clock_line_oe_n, serial_data_line_o;
	logic serial_data_line_oe_n, master_mode_enable, slave_mode_disable, read_direction_select;
	logic start_cmd, stop_cmd, transmit_holding_write, receive_holding_read, status_read, irq;
	logic transmit_holding_empty, receive_holding_full, transfer_done_flag, no_acknowledge_flag;
	logic nak, stretch, scl_pull, sda_pull;
	logic [1:0] internal_address_size;
	logic [2:0] clock_divider_exponent;
	logic [3:0] interrupt_enable_reg;
	logic [6:0] device_address_field;
	logic [7:0] clock_high_divider, clock_low_divider, transmit_holding_reg, receive_holding_reg;
	logic [7:0] txb, got, adr;
	logic [23:0] internal_address_bytes;
	logic [31:0] s;
	int nst, nsp, macks, errors, cmp_count, k;
	wire scl = (serial_clock_line_oe_n | serial_clock_line_o) & ~scl_pull;
	wire sda = (serial_data_line_oe_n | serial_data_line_o) & ~sda_pull;
	wire serial_clock_line_i = scl;
	wire serial_data_line_i = sda;
	wire [3:0] fl = {~transfer_done_flag, transmit_holding_empty, receive_holding_full,
		transfer_done_flag};
	twm_master twm_master_inst (.*);
	twm_slave_model twm_slave_model_inst (.*);
	function logic [7:0] rnd();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s[7:0];
	endfunction
	task chk(input logic [7:0] a, e, input string m);
		cmp_count++;
		if (a !== e) begin
			errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task print_verdict();
		$display("errors %0d, comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wt(input int w);
		for (k = 0; k < 20000 && !fl[w]; k++)
			@(negedge ref_clk);
		if (k == 20000) begin
			errors++;
			$display("wrong value at %0t: timeout", $time);
			print_verdict();
		end
	endtask
	// Pulses last one cycle and a quiet cycle follows, so pulses never merge
	task go(input logic [4:0] p);
		{transmit_holding_write, start_cmd, stop_cmd, receive_holding_read, status_read} = p;
		@(negedge ref_clk);
		{transmit_holding_write, start_cmd, stop_cmd, receive_holding_read, status_read} = 0;
		@(negedge ref_clk);
	endtask
	task wr(input int n);
		logic [7:0] d, p;
		int b, j;
		read_direction_select = 0;
		internal_address_size = 0;
		device_address_field = 7'(rnd());
		interrupt_enable_reg = 4'(rnd());
		stretch = rnd() > 8'h7F;
		b = nsp;
		for (j = 0; j < n; j++) begin
			p = d;
			d = rnd();
			transmit_holding_reg = d;
			go(5'h10);
			wt(2);
			if (j == 0)
				chk(adr, {device_address_field, 1'b0}, "write address");
			else
				chk(got, p, "data byte");
		end
		wt(0);
		@(negedge ref_clk);
		chk(got, d, "last byte");
		chk(8'(nsp - b), 8'h01, "stop count");
		chk(transmit_holding_empty, 8'h01, "tx empty");
		chk(irq, 8'(|({no_acknowledge_flag, fl[2:0]} & interrupt_enable_reg)), "irq");
	endtask
	task rd(input logic [1:0] z, input int n);
		logic [7:0] r;
		int b, m, j;
		r = rnd();
		internal_address_size = z;
		internal_address_bytes = {rnd(), rnd(), rnd()};
		device_address_field = {z == 2'h1 ? 5'h1E : r[6:2], r[1:0]};
		txb = rnd();
		read_direction_select = 1;
		stretch = r[7];
		b = nst;
		m = macks;
		go(n == 1 ? 5'h0C : 5'h08);
		for (j = 0; j < n; j++) begin
			wt(1);
			chk(receive_holding_reg, txb, "read byte");
			if (j == n - 2)
				go(5'h04);
			go(5'h02);
			chk(receive_holding_full, 8'h00, "rx clear");
		end
		wt(0);
		chk(adr, {device_address_field, 1'b1}, "read address");
		chk(8'(nst - b), z == 0 ? 8'h01 : 8'h02, "start count");
		chk(8'(macks - m), 8'(n - 1), "master acks");
		if (z != 0)
			chk(got, internal_address_bytes[7:0], "internal byte");
	endtask
	initial begin
		ref_clk = 0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		{errors, cmp_count} = 0;
		s = 32'h65D8;
		{master_mode_enable, slave_mode_disable, read_direction_select, start_cmd, stop_cmd} = 0;
		{transmit_holding_write, receive_holding_read, status_read, nak, stretch} = 0;
		{clock_divider_exponent, clock_high_divider, clock_low_divider, transmit_holding_reg} = 0;
		{device_address_field, internal_address_size, internal_address_bytes, txb} = 0;
		interrupt_enable_reg = 0;
		nrst = 0;
		repeat (6) @(negedge ref_clk);
		nrst = 1;
		{master_mode_enable, slave_mode_disable} = 2'h3;
		chk({transmit_holding_empty, transfer_done_flag}, 8'h03, "reset flags");
		repeat (3) wr(rnd() % 4 + 1);
		for (int i = 0; i < 4; i++)
			rd(2'(i), i % 2 + 1);
		nak = 1;
		read_direction_select = 0;
		internal_address_size = 0;
		interrupt_enable_reg = 4'h8;
		go(5'h10);
		wt(3);
		wt(0);
		@(negedge ref_clk);
		chk({no_acknowledge_flag, irq}, 8'h03, "no_acknowledge_flag and irq");
		go(5'h01);
		@(negedge ref_clk);
		chk({no_acknowledge_flag, irq}, 8'h00, "no_acknowledge_flag clear");
		print_verdict();
	end
endmodule
`default_nettype wire
